// *** hdl/data_tenure_ctrl.sv ***
// Data-tenure controller of the processor system bus master.
// Assumes bus inputs are active-high levels from pins, synchronised here;
// the core issues one request at a time and waits for its done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "data_tenure_regs.svh"
module data_tenure_ctrl (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Pins from the system
	input wire logic hard_reset_n_in,
	input wire logic translation_sync_input_in,
	input wire logic data_bus_grant_in,
	input wire logic transfer_ack_in,
	input wire logic transfer_error_ack_in,
	input wire logic data_retry_in,
	input wire logic address_retry_in,
	input wire logic [31:0] data_high_lanes_in,
	input wire logic [31:0] data_low_lanes_in,
	input wire logic [7:0] data_parity_in,
	output logic [31:0] data_high_lanes_out,
	output logic [31:0] data_low_lanes_out,
	output logic [7:0] data_parity_out,
	output logic data_high_oe_out,
	output logic data_low_oe_out,
	output logic burst_indicator_out,
	output logic [2:0] transfer_size_out,
	output logic tenure_busy_out,
	// Core request side
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire data_tenure_pkg::xfer_kind_type req_kind_in,
	input wire logic [2:0] req_size_in,
	input wire logic req_fp_double_in,
	input wire logic [63:0] req_wdata_in,
	output logic [63:0] load_data_out,
	output logic load_valid_out,
	output logic load_cancel_out,
	output logic done_out,
	output logic machine_check_out,
	input wire logic machine_check_ack_in,
	output logic narrow_mode_out,
	output logic retry_disable_mode_out
);
	import data_tenure_pkg::*;

	// ==================================================================
	// Pin synchronisers
	// ==================================================================
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [31:0] dh1_q, dh2_q, dl1_q, dl2_q;
	logic [7:0] dp1_q, dp2_q;

	assign raw_in = {hard_reset_n_in, translation_sync_input_in, data_bus_grant_in,
		transfer_ack_in, transfer_error_ack_in, data_retry_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge sys_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw_in[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	logic arty1_q, arty2_q;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			arty1_q <= 1'b0;
			arty2_q <= 1'b0;
			dh1_q <= 32'h0;
			dh2_q <= 32'h0;
			dl1_q <= 32'h0;
			dl2_q <= 32'h0;
			dp1_q <= 8'h0;
			dp2_q <= 8'h0;
		end else begin
			arty1_q <= address_retry_in;
			arty2_q <= arty1_q;
			dh1_q <= data_high_lanes_in;
			dh2_q <= dh1_q;
			dl1_q <= data_low_lanes_in;
			dl2_q <= dl1_q;
			dp1_q <= data_parity_in;
			dp2_q <= dp1_q;
		end
	end

	logic hard_reset_n_s, tsync_s, grant_s, ack_s, tea_s, dretry_s;
	assign {hard_reset_n_s, tsync_s, grant_s, ack_s, tea_s, dretry_s} = s2_q;

	// ==================================================================
	// Reset-strapped modes
	// ==================================================================
	logic narrow, no_retry;
	mode_strap u_strap (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.hard_reset_n_in(hard_reset_n_s),
		.tsync_in(tsync_s),
		.retry_in(dretry_s),
		.narrow_out(narrow),
		.no_retry_out(no_retry)
	);
	assign narrow_mode_out = narrow;
	assign retry_disable_mode_out = no_retry;

	// ==================================================================
	// Beat planning
	// ==================================================================
	function automatic logic [3:0] beats_for(input xfer_kind_type k, input logic nar);
		case (k)
			KIND_LINE: beats_for = nar ? `BEATS_NARROW_BURST : `BEATS_WIDE_BURST;
			KIND_DOUBLE: beats_for = nar ? `BEATS_TWO : `BEATS_ONE;
			default: beats_for = `BEATS_ONE;
		endcase
	endfunction

	function automatic logic [2:0] size_for(input xfer_kind_type k, input logic [2:0] sz);
		case (k)
			KIND_LINE: size_for = `SIZE_BURST;
			KIND_DOUBLE: size_for = `SIZE_DOUBLE;
			KIND_IFETCH: size_for = `SIZE_WORD;
			// A plain request never carries the eight-byte code
			default: size_for = (sz == `SIZE_DOUBLE) ? `SIZE_WORD : sz;
		endcase
	endfunction

	// Eight-byte kind is only accepted for aligned floating-point doubles
	xfer_kind_type kind_eff;
	always_comb begin
		kind_eff = req_kind_in;
		if (req_kind_in == KIND_DOUBLE && !req_fp_double_in) begin
			kind_eff = KIND_SINGLE;
		end
	end

	// ==================================================================
	// Tenure state machine
	// ==================================================================
	tenure_state_type state_q;
	logic write_q;
	logic [3:0] beats_q, beat_q;
	logic [63:0] wdata_q;
	logic [2:0] size_q;
	logic burst_q;
	logic kind_small_q;
	logic check_last_q;

	// Requests wait one clock past the synchronised release, so the strap is
	// already captured when the beat plan reads the bus width; costs one
	// clock of start-up latency only
	logic hr_q;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hr_q <= 1'b0;
		end else begin
			hr_q <= hard_reset_n_s;
		end
	end

	assign req_ready_out = (state_q == ST_IDLE) && hard_reset_n_s && hr_q;
	wire start = req_valid_in && req_ready_out;
	wire beat_ack = (state_q == ST_BEAT) && ack_s && !tea_s;
	wire last_beat = beat_ack && (beat_q == beats_q - 4'h1);
	// Read cancellation the cycle after an ack, only in normal mode
	wire dretry_hit = (state_q == ST_CHECK) && !write_q && !no_retry && dretry_s;
	wire arty_window = narrow ? (kind_small_q ? beat_q == 4'h1 : beat_q == 4'h2) : beat_q == 4'h1;
	wire arty_hit = (state_q == ST_CHECK) && !no_retry && arty2_q && arty_window;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= ST_IDLE;
			beat_q <= 4'h0;
			beats_q <= 4'h1;
			write_q <= 1'b0;
			wdata_q <= 64'h0;
			size_q <= 3'h0;
			burst_q <= 1'b0;
			kind_small_q <= 1'b0;
			check_last_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_WAIT_GRANT;
						beat_q <= 4'h0;
						beats_q <= beats_for(kind_eff, narrow);
						write_q <= req_write_in;
						wdata_q <= req_wdata_in;
						size_q <= size_for(kind_eff, req_size_in);
						burst_q <= (kind_eff == KIND_LINE);
						kind_small_q <= (kind_eff != KIND_LINE) && (kind_eff != KIND_DOUBLE);
					end
				end
				ST_WAIT_GRANT: begin
					if (grant_s) begin
						state_q <= ST_BEAT;
					end
				end
				ST_BEAT: begin
					if (tea_s) begin
						state_q <= ST_DONE;
					end else if (beat_ack) begin
						beat_q <= beat_q + 4'h1;
						check_last_q <= last_beat;
						// Retry-disable and writes need no check cycle
						if (write_q || no_retry) begin
							state_q <= last_beat ? ST_DONE : ST_BEAT;
						end else begin
							state_q <= ST_CHECK;
						end
						if (write_q && narrow) begin
							wdata_q <= {wdata_q[31:0], 32'h0};
						end
					end
				end
				ST_CHECK: begin
					if (tea_s) begin
						state_q <= ST_DONE;
					end else if (dretry_hit) begin
						beat_q <= beat_q - 4'h1;
						state_q <= ST_BEAT;
					end else if (arty_hit) begin
						state_q <= ST_DONE;
					end else begin
						state_q <= check_last_q ? ST_DONE : ST_BEAT;
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ==================================================================
	// Pin drive
	// ==================================================================
	// Odd parity for each byte of a 32-bit word, bit n for byte n
	function automatic logic [3:0] lane_parity(input logic [31:0] w);
		for (int b = 0; b < 4; b++) begin
			lane_parity[b] = ~^w[8*b +: 8];
		end
	endfunction

	wire driving = (state_q == ST_BEAT) && write_q;
	always_comb begin
		data_high_oe_out = driving;
		data_low_oe_out = driving;
		tenure_busy_out = (state_q == ST_BEAT) || (state_q == ST_CHECK);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_high_lanes_out <= 32'h0;
			data_low_lanes_out <= 32'h0;
			data_parity_out <= 8'h0;
			burst_indicator_out <= 1'b0;
			transfer_size_out <= 3'h0;
		end else begin
			burst_indicator_out <= burst_q;
			transfer_size_out <= size_q;
			data_high_lanes_out <= wdata_q[63:32];
			// Narrow mode never carries data on the low lanes
			data_low_lanes_out <= narrow ? 32'h0 : wdata_q[31:0];
			data_parity_out[7:4] <= lane_parity(wdata_q[63:32]);
			data_parity_out[3:0] <= narrow ? 4'h0 : lane_parity(wdata_q[31:0]);
		end
	end

	// ==================================================================
	// Load forwarding
	// ==================================================================
	logic [63:0] hold_q;
	logic hold_v_q;
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_q <= 64'h0;
			hold_v_q <= 1'b0;
			load_data_out <= 64'h0;
			load_valid_out <= 1'b0;
			load_cancel_out <= 1'b0;
		end else begin
			load_valid_out <= 1'b0;
			load_cancel_out <= 1'b0;
			hold_v_q <= 1'b0;
			if (beat_ack && !write_q) begin
				// Unused lanes are not sampled in narrow mode
				hold_q <= narrow ? {dh2_q, 32'h0} : {dh2_q, dl2_q};
				if (no_retry) begin
					load_data_out <= narrow ? {dh2_q, 32'h0} : {dh2_q, dl2_q};
					load_valid_out <= 1'b1;
				end else begin
					hold_v_q <= 1'b1;
				end
			end
			if (hold_v_q) begin
				// Normal mode holds one clock so a late cancel can still land
				if (dretry_hit || arty_hit) begin
					load_cancel_out <= 1'b1;
				end else begin
					load_data_out <= hold_q;
					load_valid_out <= 1'b1;
				end
			end
		end
	end

	// ==================================================================
	// Completion and error reporting
	// ==================================================================
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			done_out <= 1'b0;
			machine_check_out <= 1'b0;
		end else begin
			done_out <= (state_q == ST_DONE);
			// Sticky and imprecise: the failing address is not kept; set wins over ack
			if (tea_s && (state_q == ST_BEAT || state_q == ST_CHECK)) begin
				machine_check_out <= 1'b1;
			end else if (machine_check_ack_in) begin
				machine_check_out <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/data_tenure_regs.svh ***
// Constants of the processor bus data-tenure controller.
// Assumes inclusion by the package and modules under hdl/.
`ifndef DATA_TENURE_REGS_SVH
`define DATA_TENURE_REGS_SVH

`define TRANSFER_SIZE_W 3
`define SIZE_BURST 3'h2
`define SIZE_DOUBLE 3'h0
`define SIZE_WORD 3'h4
`define BEATS_WIDE_BURST 4'h4
`define BEATS_NARROW_BURST 4'h8
`define BEATS_ONE 4'h1
`define BEATS_TWO 4'h2
`define LANE_W 32
`define PAR_W 4

`endif

// *** hdl/data_tenure_pkg.sv ***
// Types of the processor bus data-tenure controller.
// Assumes the constants header sits beside it.
`include "data_tenure_regs.svh"
package data_tenure_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_GRANT = 3'h1,
		ST_BEAT = 3'h3,
		ST_CHECK = 3'h2,
		ST_DONE = 3'h6
	} tenure_state_type;

	typedef enum logic [1:0] {
		KIND_SINGLE = 2'h0,
		KIND_DOUBLE = 2'h1,
		KIND_LINE = 2'h2,
		KIND_IFETCH = 2'h3
	} xfer_kind_type;
endpackage

// *** hdl/mode_strap.sv ***
// Reset strap capture for bus width and retry mode.
// Assumes hard_reset is already a synchronised active-low level.
`timescale 1ns/1ps
`default_nettype none
module mode_strap (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic hard_reset_n_in,
	input wire logic tsync_in,
	input wire logic retry_in,
	output logic narrow_out,
	output logic no_retry_out
);
	logic hold_q;

	// Capture on the clock after release, never under the asynchronous reset
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_q <= 1'b1;
			narrow_out <= 1'b0;
			no_retry_out <= 1'b0;
		end else begin
			hold_q <= !hard_reset_n_in;
			if (hold_q && hard_reset_n_in) begin
				narrow_out <= tsync_in;
				no_retry_out <= retry_in;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/data_tenure_ctrl_chk.sv ***
// Port checker of the data-tenure controller.
// Assumes it is bound to data_tenure_ctrl, whose port names it reuses.
`timescale 1ns/1ps
`default_nettype none
`include "data_tenure_regs.svh"
module dt_chk (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic hard_reset_n_in,
	input wire logic machine_check_ack_in,
	input wire logic tenure_busy_out,
	input wire logic data_high_oe_out,
	input wire logic data_low_oe_out,
	input wire logic [31:0] data_low_lanes_out,
	input wire logic [7:0] data_parity_out,
	input wire logic burst_indicator_out,
	input wire logic [2:0] transfer_size_out,
	input wire logic load_valid_out,
	input wire logic load_cancel_out,
	input wire logic machine_check_out,
	input wire logic narrow_mode_out,
	input wire logic retry_disable_mode_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	// ==========================================
	// Assertions
	property p_release; !tenure_busy_out |-> !data_high_oe_out && !data_low_oe_out; endproperty
	a_release: assert property (p_release) else $error("data lanes driven outside a tenure");
	property p_narrow; narrow_mode_out && data_high_oe_out |->
		data_low_oe_out && data_low_lanes_out == 32'h0 && data_parity_out[3:0] == 4'h0; endproperty
	a_narrow: assert property (p_narrow) else $error("low lanes used in narrow mode");
	property p_burst; burst_indicator_out |-> transfer_size_out == `SIZE_BURST; endproperty
	a_burst: assert property (p_burst) else $error("burst without burst size code");
	// Six cycles covers the strap synchroniser and capture
	property p_hold; hard_reset_n_in && $past(hard_reset_n_in, 6) |-> $stable(narrow_mode_out) && $stable(retry_disable_mode_out); endproperty
	a_hold: assert property (p_hold) else $error("mode changed in operation");
	property p_nocancel; retry_disable_mode_out |-> !load_cancel_out; endproperty
	a_nocancel: assert property (p_nocancel) else $error("cancel in retry-disable mode");
	property p_sticky; machine_check_out && !machine_check_ack_in |=> machine_check_out; endproperty
	a_sticky: assert property (p_sticky) else $error("exception request lost");
	property p_wquiet; data_high_oe_out |-> !load_valid_out && !load_cancel_out; endproperty
	a_wquiet: assert property (p_wquiet) else $error("load result during a write");
	property p_teaend; $rose(machine_check_out) |-> ##[0:16] !tenure_busy_out; endproperty
	a_teaend: assert property (p_teaend) else $error("tenure kept after error");
	property p_one; load_valid_out || load_cancel_out |-> !(load_valid_out && load_cancel_out) ##1 !load_valid_out && !load_cancel_out; endproperty
	a_one: assert property (p_one) else $error("beat outcome not a single pulse");
endmodule
`default_nettype wire

// *** tb/dt_partner.sv ***
// Memory controller and arbiter model facing the data-tenure controller.
// Assumes active-high bus levels; the bench sets stall, retry and error.
`timescale 1ns/1ps
`default_nettype none
module dt_partner (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic busy_in,
	input wire logic write_in,
	input wire logic stall_in,
	input wire logic retry_in,
	input wire logic err_in,
	input wire logic strap_retry_in,
	input wire logic arty_in,
	output logic grant_out,
	output logic ack_out,
	output logic tea_out,
	output logic dretry_out,
	output logic arty_out,
	output logic [31:0] high_out,
	output logic [31:0] low_out
);
	logic [2:0] cnt_q = 3'h0;
	logic [1:0] beat_q = 2'h0;
	logic [31:0] pat_q = 32'h0;
	logic [31:0] pat_d;
	logic g_q = 1'b0, a_q = 1'b0, t_q = 1'b0, d_q = 1'b0, used_q = 1'b0, ar_q = 1'b0;
	logic [63:0] rd_q[$];
	// ==========================================
	// Answers
	// Lanes change every cycle so a stale sample never matches
	assign pat_d = pat_q * 32'h0019660D + 32'h3C6EF35F;
	assign high_out = pat_q;
	assign low_out = ~pat_q;
	assign grant_out = g_q;
	assign ack_out = a_q;
	assign tea_out = t_q;
	assign arty_out = ar_q;
	assign dretry_out = d_q | strap_retry_in;
	always @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= 3'h0;
			beat_q <= 2'h0;
			g_q <= 1'b0;
			a_q <= 1'b0;
			t_q <= 1'b0;
			d_q <= 1'b0;
			used_q <= 1'b0;
			ar_q <= 1'b0;
		end else begin
			pat_q <= pat_d;
			g_q <= !stall_in;
			cnt_q <= busy_in ? cnt_q + 3'h1 : 3'h0;
			beat_q <= busy_in ? beat_q : 2'h0;
			a_q <= 1'b0;
			t_q <= 1'b0;
			// Retry also follows write acks, which the controller must ignore
			d_q <= a_q && retry_in && !used_q;
			used_q <= retry_in && busy_in && (used_q || d_q);
			ar_q <= a_q && arty_in && !write_in;
			// Acks at least eight cycles apart (a stall at the slot adds eight more), so none lands once the tenure is over
			if (busy_in && cnt_q == 3'h7 && !stall_in) begin
				beat_q <= beat_q + 2'h1;
				if (err_in && beat_q == 2'h2) begin
					t_q <= 1'b1;
				end else begin
					a_q <= 1'b1;
					if (!write_in) begin
						rd_q.push_back({pat_d, ~pat_d});
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/data_tenure_ctrl_tb.sv ***
// Self-checking bench of the data-tenure controller.
// Assumes package, partner model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "data_tenure_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module data_tenure_ctrl_tb;
	import data_tenure_pkg::*;
	typedef struct {int lv; int lc;} note_type;
	logic sys_clk_in = 1'b0, rstn_in = 1'b0, hard_reset_n_in = 1'b0, translation_sync_input_in = 1'b0;
	logic data_bus_grant_in, transfer_ack_in, transfer_error_ack_in, data_retry_in;
	logic address_retry_in;
	logic [31:0] data_high_lanes_in, data_low_lanes_in, data_high_lanes_out, data_low_lanes_out;
	logic [7:0] data_parity_in = 8'h00, data_parity_out;
	logic data_high_oe_out, data_low_oe_out, burst_indicator_out, tenure_busy_out, req_ready_out;
	logic [2:0] transfer_size_out, req_size_in = 3'h0;
	logic req_valid_in = 1'b0, req_write_in = 1'b0, req_fp_double_in = 1'b0, machine_check_ack_in = 1'b0;
	xfer_kind_type req_kind_in = KIND_SINGLE;
	logic [63:0] req_wdata_in = 64'h0, load_data_out;
	logic load_valid_out, load_cancel_out, done_out, machine_check_out, narrow_mode_out, retry_disable_mode_out;
	logic stall = 1'b0, retry = 1'b0, err = 1'b0, strap_rty = 1'b0, arty = 1'b0;
	logic [31:0] rng = 32'h000029D1;
	logic [31:0] exp_hi;
	note_type exp_q[$];
	note_type nt;
	int fails = 0, num_checks = 0, n_lv = 0, n_lc = 0, since = 0, lat = 0, lat_n = 0, tn = 0, wb = 0;
	data_tenure_ctrl u_dut (.*);
	dt_partner u_far (.sys_clk_in, .rstn_in, .busy_in(tenure_busy_out), .write_in(data_high_oe_out), .stall_in(stall),
		.retry_in(retry), .err_in(err), .strap_retry_in(strap_rty), .arty_in(arty), .grant_out(data_bus_grant_in),
		.ack_out(transfer_ack_in), .tea_out(transfer_error_ack_in), .dretry_out(data_retry_in),
		.arty_out(address_retry_in), .high_out(data_high_lanes_in), .low_out(data_low_lanes_in));
	// ==========================================
	// Stimulus helpers
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic summarize();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic strap(input logic nw, input logic nd);
		@(negedge sys_clk_in);
		hard_reset_n_in = 1'b0;
		translation_sync_input_in = nw;
		strap_rty = nd;
		repeat (6) @(negedge sys_clk_in);
		hard_reset_n_in = 1'b1;
		repeat (8) @(negedge sys_clk_in);
		strap_rty = 1'b0;
		translation_sync_input_in = !nw;
		`CHK(narrow_mode_out, nw)
		`CHK(retry_disable_mode_out, nd)
	endtask
	task automatic run(input logic w, input xfer_kind_type k, input logic [2:0] s, input logic f, input int n,
		input int c, input logic b);
		int i;
		logic [2:0] exp_s;
		exp_q.push_back('{n, c});
		exp_s = (k == KIND_LINE) ? `SIZE_BURST : (k == KIND_IFETCH) ? `SIZE_WORD :
			(k == KIND_DOUBLE && f) ? `SIZE_DOUBLE : (s == `SIZE_DOUBLE) ? `SIZE_WORD : s;
		@(negedge sys_clk_in);
		req_wdata_in = {rnd(), rnd()};
		req_write_in = w;
		req_kind_in = k;
		req_size_in = s;
		req_fp_double_in = f;
		req_valid_in = 1'b1;
		for (i = 0; i < 50 && req_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
		@(negedge sys_clk_in);
		req_valid_in = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		`CHK(burst_indicator_out, b)
		`CHK(transfer_size_out, exp_s)
		for (i = 0; i < 600 && done_out !== 1'b1; i++) @(negedge sys_clk_in);
		if (i == 600) fails++;
		repeat (8) @(negedge sys_clk_in);
		tn++;
		$display("test %0d done", tn);
	endtask
	// ==========================================
	// Clock, watchdog, stalls and result monitor
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	initial begin
		#500000;
		fails++;
		summarize();
	end
	always @(negedge sys_clk_in) stall <= (rnd() & 32'h3) == 32'h0;
	always @(posedge sys_clk_in) begin
		#1;
		since = (transfer_ack_in === 1'b1) ? 0 : since + 1;
		// Write beats: the system samples the lanes while its ack stands
		if (transfer_ack_in === 1'b1 && data_high_oe_out === 1'b1) begin
			exp_hi = (!narrow_mode_out || wb == 0) ? req_wdata_in[63:32] : (wb == 1) ? req_wdata_in[31:0] : 32'h0;
			`CHK(data_high_lanes_out, exp_hi)
			`CHK(data_low_lanes_out, (narrow_mode_out ? 32'h0 : req_wdata_in[31:0]))
			wb++;
		end
		if (load_valid_out === 1'b1) begin
			lat = since;
			n_lv++;
			`CHK(load_data_out, (narrow_mode_out ? {u_far.rd_q[0][63:32], 32'h0} : u_far.rd_q[0]))
			u_far.rd_q.delete(0);
		end
		if (load_cancel_out === 1'b1) begin
			n_lc++;
			u_far.rd_q.delete(0);
		end
		if (done_out === 1'b1) begin
			nt = exp_q.pop_front();
			`CHK(n_lv, nt.lv)
			`CHK(n_lc, nt.lc)
			n_lv = 0;
			n_lc = 0;
			wb = 0;
		end
	end
	// ==========================================
	// Scenarios
	initial begin
		repeat (5) @(negedge sys_clk_in);
		rstn_in = 1'b1;
		strap('0, '0);
		run('0, KIND_SINGLE, `SIZE_WORD, '0, 1, 0, '0);
		lat_n = lat;
		run('0, KIND_LINE, `SIZE_BURST, '0, 4, 0, '1);
		retry = 1'b1;
		run('0, KIND_SINGLE, `SIZE_WORD, '0, 1, 1, '0);
		run('1, KIND_LINE, `SIZE_BURST, '0, 0, 0, '1);
		retry = 1'b0;
		err = 1'b1;
		run('1, KIND_LINE, `SIZE_BURST, '0, 0, 0, '1);
		err = 1'b0;
		`CHK(machine_check_out, 1'b1)
		machine_check_ack_in = 1'b1;
		@(negedge sys_clk_in);
		machine_check_ack_in = 1'b0;
		@(negedge sys_clk_in);
		`CHK(machine_check_out, 1'b0)
		arty = 1'b1;
		run('0, KIND_SINGLE, `SIZE_WORD, '0, 0, 1, '0);
		arty = 1'b0;
		strap('1, '0);
		run('0, KIND_LINE, `SIZE_BURST, '0, 8, 0, '1);
		run('0, KIND_DOUBLE, `SIZE_DOUBLE, '1, 2, 0, '0);
		run('0, KIND_DOUBLE, `SIZE_DOUBLE, '0, 1, 0, '0);
		run('0, KIND_IFETCH, `SIZE_WORD, '0, 1, 0, '0);
		run('1, KIND_DOUBLE, `SIZE_DOUBLE, '1, 0, 0, '0);
		run('1, KIND_LINE, `SIZE_BURST, '0, 0, 0, '1);
		strap('0, '1);
		run('0, KIND_SINGLE, `SIZE_WORD, '0, 1, 0, '0);
		`CHK(lat, lat_n - 1)
		summarize();
	end
endmodule
bind data_tenure_ctrl dt_chk u_chk (.*);
`default_nettype wire
